// ==== hw/wdit_defs.svh ====
// register map, field positions, reset values and counts of the watchdog interval timer
`ifndef WDIT_DEFS_SVH
`define WDIT_DEFS_SVH

`define WDIT_ADDR_PERIOD_SEL     16'hff42
`define WDIT_ADDR_MODE_CTRL      16'hfff9
`define WDIT_PERIOD_SEL_RESET    3'h0
`define WDIT_PERIOD_SEL_MASK     8'h07
`define WDIT_MODE_RESET          8'h00
`define WDIT_BIT_RESTART         3'h7
`define WDIT_BIT_GUARD_MODE      3'h4
`define WDIT_BIT_RESET_SEL       3'h3
`define WDIT_PRESCALE_BITS       4
`define WDIT_COUNT_BITS          16
`define WDIT_MIN_PERIOD_LOG2     5'h0c
`define WDIT_TOP_CODE_LOG2       5'h14
`define WDIT_IRQ_DEFAULT_RANK    4'h0

`endif

// ==== hw/wdit_pkg.sv ====
// types shared by the watchdog interval timer
package wdit_pkg;

	// cpu access to the two control registers
	typedef struct packed {
		logic        wr;
		logic        bit_wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  data;
		logic [2:0]  bit_idx;
		logic        bit_val;
	} wdit_cpu_req_type;

	typedef enum logic [0:0] {
		WDIT_STOPPED  = 1'b0,
		WDIT_COUNTING = 1'b1
	} wdit_run_state_type;

	// overflow requests toward interrupt and reset logic
	typedef struct packed {
		logic periodic_timer_irq;
		logic nmi_req;
		logic reset_req;
	} wdit_event_type;

	typedef struct packed {
		wdit_run_state_type run;
		logic [2:0]         overflow_period_select;
		logic               guard_mode_enable;
		logic               reset_on_overflow_sel;
		logic [15:0]        count;
		wdit_event_type     events;
		logic [7:0]         rd_data;
	} wdit_state_type;

endpackage : wdit_pkg

// ==== hw/wdit_prescaler.sv ====
// prescaler of the main clock, advancing only while run_in is high
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defs.svh"

module wdit_prescaler (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic run_in,
	output var  logic tick_out
);

	logic [`WDIT_PRESCALE_BITS-1:0] div;
	logic [`WDIT_PRESCALE_BITS-1:0] next_div;

	// never cleared by a restart, only by reset
	always_comb begin
		next_div = run_in ? div + 1'b1 : div;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			div <= '0;
		end else begin
			div <= next_div;
		end
	end

	assign tick_out = run_in && (div == {`WDIT_PRESCALE_BITS{1'b1}});

endmodule : wdit_prescaler
`default_nettype wire

// ==== hw/wdit_top.sv ====
// watchdog and interval timer with its two control registers
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defs.svh"

module wdit_top (
	input  wire logic                      clk_in,
	input  wire logic                      rst_n_in,
	input  wire logic                      clk_en_in,
	input  wire wdit_pkg::wdit_cpu_req_type cpu_req_in,
	input  wire logic                      stop_mode_in,
	input  wire logic                      subclock_cpu_in,
	output var  logic [7:0]                rd_data_out,
	output var  logic                      periodic_timer_irq_out,
	output var  logic                      nmi_req_out,
	output var  logic                      reset_req_out,
	output var  logic                      counting_out,
	output var  logic [3:0]                irq_default_rank_out
);

	wdit_pkg::wdit_state_type state;
	wdit_pkg::wdit_state_type next_state;

	logic        tick;
	logic        count_enable;
	logic        sel_hit;
	logic        mode_hit;
	logic [15:0] limit;
	logic [4:0]  period_log2;
	logic [7:0]  mode_read;
	logic        sel_byte_wr;
	logic        mode_byte_wr;
	logic        mode_bit_set;
	logic        set_guard;
	logic        set_reset_sel;
	logic        restart_req;
	logic        overflow;
	logic [15:0] count_step;
	logic [7:0]  read_mux;
	wdit_pkg::wdit_event_type overflow_events;

	// halt keeps counting; stop and subclock freeze it
	assign count_enable = clk_en_in && (state.run == wdit_pkg::WDIT_COUNTING)
		&& !stop_mode_in && !subclock_cpu_in;

	wdit_prescaler u_prescaler (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.run_in   (count_enable),
		.tick_out (tick)
	);

	assign sel_hit  = cpu_req_in.addr == `WDIT_ADDR_PERIOD_SEL;
	assign mode_hit = cpu_req_in.addr == `WDIT_ADDR_MODE_CTRL;

	// code 7 skips 2^19 and gives 2^20
	always_comb begin
		unique case (state.overflow_period_select)
			3'h0: begin
				period_log2 = `WDIT_MIN_PERIOD_LOG2;
			end
			3'h1: begin
				period_log2 = `WDIT_MIN_PERIOD_LOG2 + 5'h01;
			end
			3'h2: begin
				period_log2 = `WDIT_MIN_PERIOD_LOG2 + 5'h02;
			end
			3'h3: begin
				period_log2 = `WDIT_MIN_PERIOD_LOG2 + 5'h03;
			end
			3'h4: begin
				period_log2 = `WDIT_MIN_PERIOD_LOG2 + 5'h04;
			end
			3'h5: begin
				period_log2 = `WDIT_MIN_PERIOD_LOG2 + 5'h05;
			end
			3'h6: begin
				period_log2 = `WDIT_MIN_PERIOD_LOG2 + 5'h06;
			end
			3'h7: begin
				period_log2 = `WDIT_TOP_CODE_LOG2;
			end
		endcase
	end

	// overflow after 2^(log2 - prescale) prescaler ticks
	assign limit = 16'(({16'h0000, 16'h0001} << (period_log2 - 5'(`WDIT_PRESCALE_BITS))) - 32'h0000_0001);

	always_comb begin
		mode_read = 8'h00;
		mode_read[`WDIT_BIT_RESTART]    = state.run == wdit_pkg::WDIT_COUNTING;
		mode_read[`WDIT_BIT_GUARD_MODE] = state.guard_mode_enable;
		mode_read[`WDIT_BIT_RESET_SEL]  = state.reset_on_overflow_sel;
	end

	// byte write wins over a bit write in the same cycle
	assign sel_byte_wr  = cpu_req_in.wr && sel_hit;
	assign mode_byte_wr = cpu_req_in.wr && mode_hit;
	assign mode_bit_set = !cpu_req_in.wr && cpu_req_in.bit_wr && mode_hit && cpu_req_in.bit_val;

	// zero writes never clear a set bit
	assign set_guard     = (mode_byte_wr && cpu_req_in.data[`WDIT_BIT_GUARD_MODE])
		|| (mode_bit_set && cpu_req_in.bit_idx == `WDIT_BIT_GUARD_MODE);
	assign set_reset_sel = (mode_byte_wr && cpu_req_in.data[`WDIT_BIT_RESET_SEL])
		|| (mode_bit_set && cpu_req_in.bit_idx == `WDIT_BIT_RESET_SEL);
	assign restart_req   = (mode_byte_wr && cpu_req_in.data[`WDIT_BIT_RESTART])
		|| (mode_bit_set && cpu_req_in.bit_idx == `WDIT_BIT_RESTART);
	assign overflow      = count_enable && tick && (state.count == limit);
	assign count_step    = state.count + 16'h0001;

	// overflow action chosen by the two mode bits
	always_comb begin
		overflow_events = '0;
		if (overflow) begin
			unique case ({state.guard_mode_enable, state.reset_on_overflow_sel})
				2'b00, 2'b01: begin
					overflow_events.periodic_timer_irq = 1'b1;
				end
				2'b10: begin
					overflow_events.nmi_req = 1'b1;
				end
				2'b11: begin
					overflow_events.reset_req = 1'b1;
				end
			endcase
		end
	end

	// unmapped addresses read as zero
	always_comb begin
		read_mux = 8'h00;
		if (sel_hit) begin
			read_mux = {5'h00, state.overflow_period_select};
		end else if (mode_hit) begin
			read_mux = mode_read;
		end
	end

	always_comb begin
		next_state        = state;
		next_state.events = overflow_events;
		if (count_enable && tick) begin
			if (overflow) begin
				next_state.count = 16'h0000;
			end else begin
				next_state.count = count_step;
			end
		end
		if (sel_byte_wr) begin
			next_state.overflow_period_select = cpu_req_in.data[2:0];
		end
		if (set_guard) begin
			next_state.guard_mode_enable = 1'b1;
		end
		if (set_reset_sel) begin
			next_state.reset_on_overflow_sel = 1'b1;
		end
		// a restart beats a same-cycle overflow, pulse still goes out
		if (restart_req) begin
			next_state.run   = wdit_pkg::WDIT_COUNTING;
			next_state.count = 16'h0000;
		end
		if (cpu_req_in.rd) begin
			next_state.rd_data = read_mux;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state.run                    <= wdit_pkg::WDIT_STOPPED;
			state.overflow_period_select <= `WDIT_PERIOD_SEL_RESET;
			state.guard_mode_enable      <= 1'b0;
			state.reset_on_overflow_sel  <= 1'b0;
			state.count                  <= '0;
			state.events                 <= '0;
			state.rd_data                <= 8'h00;
		end else if (clk_en_in) begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			irq_default_rank_out <= 4'h0;
		end else begin
			irq_default_rank_out <= `WDIT_IRQ_DEFAULT_RANK;
		end
	end

	assign rd_data_out            = state.rd_data;
	assign periodic_timer_irq_out = state.events.periodic_timer_irq;
	assign nmi_req_out            = state.events.nmi_req;
	assign reset_req_out          = state.events.reset_req;
	assign counting_out           = state.run == wdit_pkg::WDIT_COUNTING;

endmodule : wdit_top
`default_nettype wire

// ==== sim/wdit_properties.sv ====
// port assertions of the watchdog interval timer
`timescale 1ns/1ps
`default_nettype none
module wdit_properties (
	input wire logic                       clk_in,
	input wire logic                       rst_n_in,
	input wire logic                       clk_en_in,
	input wire wdit_pkg::wdit_cpu_req_type cpu_req_in,
	input wire logic                       stop_mode_in,
	input wire logic                       subclock_cpu_in,
	input wire logic [7:0]                 rd_data_out,
	input wire logic                       periodic_timer_irq_out,
	input wire logic                       nmi_req_out,
	input wire logic                       reset_req_out,
	input wire logic                       counting_out,
	input wire logic [3:0]                 irq_default_rank_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic [2:0] ev = {periodic_timer_irq_out, nmi_req_out, reset_req_out};
	wire logic       frz = stop_mode_in || subclock_cpu_in;
	a_rank_top: assert property (irq_default_rank_out == 4'h0) else $error("rank");
	a_one_event: assert property ($onehot0(ev)) else $error("two events");
	a_pulse_once: assert property (ev != 3'h0 && clk_en_in |=> ev == 3'h0) else $error("long pulse");
	a_run_sticky: assert property (counting_out |=> counting_out) else $error("run dropped");
	a_idle_quiet: assert property (!counting_out |-> ev == 3'h0) else $error("idle event");
	a_restart_runs: assert property (
		clk_en_in && cpu_req_in.wr && cpu_req_in.addr == 16'hfff9 && cpu_req_in.data[7] |=> counting_out)
		else $error("no start");
	a_frozen_quiet: assert property (
		frz && $past(frz) && $past(frz, 2) |-> ev == 3'h0) else $error("frozen event");
	a_mode_zeros: assert property (
		clk_en_in && cpu_req_in.rd && cpu_req_in.addr == 16'hfff9 |=> (rd_data_out & 8'h67) == 8'h00)
		else $error("unused bits");
endmodule : wdit_properties
bind wdit_top wdit_properties u_wdit_properties (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
	.cpu_req_in(cpu_req_in), .stop_mode_in(stop_mode_in), .subclock_cpu_in(subclock_cpu_in),
	.rd_data_out(rd_data_out), .periodic_timer_irq_out(periodic_timer_irq_out), .nmi_req_out(nmi_req_out),
	.reset_req_out(reset_req_out), .counting_out(counting_out), .irq_default_rank_out(irq_default_rank_out));
`default_nettype wire

// ==== sim/wdit_far_end.sv ====
// request sink standing for interrupt and reset logic
`timescale 1ns/1ps
`default_nettype none
module wdit_far_end (
	input  wire logic       clk_in,
	input  wire logic [2:0] ev_in,
	output var  int         n_ev_out
);
	initial n_ev_out = 0;
	always @(posedge clk_in) n_ev_out <= n_ev_out + $countones(ev_in);
endmodule : wdit_far_end
`default_nettype wire

// ==== sim/tb_wdit_top.sv ====
// self-checking bench of the watchdog interval timer
`timescale 1ns/1ps
`default_nettype none
module tb_wdit_top;
	logic                       clk_in = 1'b0, rst_n_in = 1'b0, stop = 1'b0, sub = 1'b0, en = 1'b1;
	wire logic                  run;
	wdit_pkg::wdit_cpu_req_type req = '0;
	logic [7:0]                 rdd;
	logic [3:0]                 rank;
	wire logic [2:0]            ev;
	int                         n_ev, n_errors = 0, n_compared = 0, cyc = 0, at, c0;
	// bit write, address, data, readback
	logic [32:0] rows [7] = '{{1'b0, 16'hff42, 16'hff07}, {1'b1, 16'hff42, 16'h0907}, {1'b0, 16'hff42, 16'h0000},
		{1'b0, 16'hff40, 16'hff00}, {1'b1, 16'hfff9, 16'h0b08}, {1'b0, 16'hfff9, 16'h0008}, {1'b1, 16'hfff9, 16'h0308}};
	wdit_top u_wdit_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(en), .cpu_req_in(req),
		.stop_mode_in(stop), .subclock_cpu_in(sub), .rd_data_out(rdd), .periodic_timer_irq_out(ev[2]),
		.nmi_req_out(ev[1]), .reset_req_out(ev[0]), .counting_out(run), .irq_default_rank_out(rank));
	wdit_far_end u_wdit_far_end (.clk_in(clk_in), .ev_in(ev), .n_ev_out(n_ev));
	initial forever #50 clk_in = !clk_in;
	task automatic print_verdict();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic bw, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_in);
		req = '{!bw, bw, 1'b0, a, d, d[2:0], d[3]};
		@(negedge clk_in);
		req = '0;
	endtask : wr
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk_in);
		req = '{1'b0, 1'b0, 1'b1, a, 8'h00, 3'h0, 1'b0};
		@(negedge clk_in);
		req = '0;
		@(negedge clk_in);
		chk({8'h00, rdd}, {8'h00, e});
	endtask : rdc
	// wait for one request line, at stays -1 when none came
	task automatic wt(input int sel, lim);
		at = -1;
		for (int k = 0; k < lim && at < 0; k++) begin
			@(negedge clk_in);
			if (ev[sel] === 1'b1) at = cyc;
		end
	endtask : wt
	task automatic rst();
		@(negedge clk_in);
		rst_n_in = 1'b0;
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
	endtask : rst
	initial begin
		rst();
		chk({12'h000, rank}, 16'h0000);
		rdc(16'hff42, 8'h00);
		rdc(16'hfff9, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][32], rows[i][31:16], rows[i][15:8]);
			rdc(rows[i][31:16], rows[i][7:0]);
		end
		en = 1'b0;
		wr(1'b0, 16'hff42, 8'h05);
		en = 1'b1;
		rdc(16'hff42, 8'h00);
		rst();
		chk({15'h0000, run}, 16'h0000);
		wr(1'b0, 16'hfff9, 8'h80);
		c0 = cyc;
		chk({15'h0000, run}, 16'h0001);
		wt(2, 4200);
		chk(16'(at - c0 > 4074 && at - c0 < 4100), 16'h0001);
		c0 = at;
		wt(2, 4200);
		chk(16'(at - c0), 16'h1000);
		wr(1'b0, 16'hfff9, 8'h80);
		stop = 1'b1;
		wt(2, 5000);
		chk(16'(at), 16'hffff);
		{stop, sub} = 2'b01;
		wt(2, 5000);
		chk(16'(at), 16'hffff);
		sub = 1'b0;
		rst();
		wr(1'b0, 16'hfff9, 8'h90);
		repeat (3) begin
			wt(1, 3000);
			chk(16'(at), 16'hffff);
			wr(1'b0, 16'hfff9, 8'h80);
		end
		rdc(16'hfff9, 8'h90);
		wt(1, 4200);
		chk(16'(at > 0), 16'h0001);
		rst();
		wr(1'b1, 16'hfff9, 8'h0c);
		wr(1'b1, 16'hfff9, 8'h0b);
		wr(1'b1, 16'hfff9, 8'h0f);
		rdc(16'hfff9, 8'h98);
		wt(0, 4200);
		chk(16'(at > 0), 16'h0001);
		@(negedge clk_in);
		chk(16'(n_ev), 16'h0004);
		print_verdict();
	end
endmodule : tb_wdit_top
`default_nettype wire
